// File: ivap_top.sv
// interrupt arbitration, vectoring and return sequencing
//
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module ivap_top (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire ivap_pkg::ivap_core_t CORE,
  input  wire logic [9:0]        PEND,
  input  wire logic [9:0]        ENABLE,
  input  wire logic              TRAP_PEND,
  input  wire logic              NMI_BUSY,
  input  wire logic [7:0]        MEM_DATA,
  input  wire logic [14:0]       STACK_IN,
  input  wire logic [7:0]        ADDR,
  input  wire logic [7:0]        WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic [7:0]             RDATA,
  output logic                   MEM_RD,
  output logic [14:0]            MEM_ADDR,
  output logic                   STACK_PUSH,
  output logic [14:0]            STACK_OUT,
  output logic                   STACK_POP,
  output logic                   PC_LOAD,
  output logic [14:0]            PC_VALUE,
  output logic                   GLOBAL_INTERRUPT_ENABLE,
  output logic                   BUSY
);
  import ivap_pkg::*;

  // ===================================================
  // state
  ivap_state_t state_q;
  ivap_state_t state_d;
  logic        gie_q;
  logic        busy_q;
  logic [3:0]  div_q;
  logic [3:0]  tcnt_q;
  logic        tc_en;
  logic [6:0]  tbase_q;
  logic [7:0]  tofs_q;
  logic [7:0]  vhi_q;
  logic        mem_rd_q;
  logic [14:0] mem_addr_q;
  logic        push_q;
  logic [14:0] push_data_q;
  logic        pop_q;
  logic        pc_load_q;
  logic [14:0] pc_value_q;
  logic [7:0]  rdata_q;

  // ===================================================
  // arbitration
  logic [9:0]  act;
  logic        any_act;
  logic        take;
  logic [7:0]  win_ofs;
  logic [6:0]  vis_block;
  logic        in_idle;
  logic        vis_go;
  logic        return_from_interrupt_op_go;

  assign act     = PEND & ENABLE;
  assign any_act = TRAP_PEND | (|act);
  assign in_idle = (state_q == ST_IDLE);
  assign vis_go  = in_idle & CORE.op_vis;
  assign return_from_interrupt_op_go = in_idle & CORE.op_return_from_interrupt_op & ~CORE.op_vis;
  // checked only at an instruction start; the trap never starts an acknowledge here
  assign take    = in_idle & CORE.instr_start & ~CORE.op_vis &
                   ~CORE.op_return_from_interrupt_op & gie_q & (|act) & ~NMI_BUSY;

  // lowest rank first, so the highest active slot is the last to win
  always_comb begin
    win_ofs = OFS_DEFAULT;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (act[i]) begin
        win_ofs = SLOT_OFS[i];
      end
    end
    if (TRAP_PEND) begin
      win_ofs = OFS_TRAP;
    end
  end

  // a select op in the last byte of a block reads the next block's table
  assign vis_block = (CORE.op_pc[7:0] == BLOCK_LAST) ?
                     CORE.op_pc[14:8] + 7'd1 : CORE.op_pc[14:8];

  // ===================================================
  // instruction-cycle divider
  assign tc_en = (div_q == TC_CLKS - 4'd1);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      div_q <= 4'd0;
    end else if (take || tc_en) begin
      div_q <= 4'd0;
    end else begin
      div_q <= div_q + 4'd1;
    end
  end

  // ===================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (vis_go) begin
          state_d = ST_FHI;
        end else if (return_from_interrupt_op_go) begin
          state_d = ST_POP;
        end else if (take) begin
          state_d = ST_ACK;
        end
      end
      ST_ACK: begin
        if (tc_en && tcnt_q == ACK_TC - 4'd1) begin
          state_d = ST_IDLE;
        end
      end
      ST_FHI:   state_d = ST_FLO;
      ST_FLO:   state_d = ST_FWAIT;
      ST_FWAIT: state_d = ST_IDLE;
      ST_POP:   state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_IDLE;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q  <= (state_d != ST_IDLE);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tcnt_q <= 4'd0;
    end else if (take) begin
      tcnt_q <= 4'd0;
    end else if (state_q == ST_ACK && tc_en) begin
      tcnt_q <= tcnt_q + 4'd1;
    end
  end

  // ===================================================
  // global enable: return set wins over any clear
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      gie_q <= GIE_RST;
    end else if (return_from_interrupt_op_go) begin
      gie_q <= 1'b1;
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (WR && ADDR == REG_CTRL) begin
      gie_q <= WDATA[CTRL_GIE];
    end
  end

  // ===================================================
  // stack traffic
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      push_q      <= 1'b0;
      push_data_q <= 15'h0000;
      pop_q       <= 1'b0;
    end else begin
      push_q <= take;
      pop_q  <= return_from_interrupt_op_go;
      if (take) begin
        push_data_q <= CORE.op_pc;
      end
    end
  end

  // ===================================================
  // vector fetch, high byte first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tbase_q    <= 7'h00;
      tofs_q     <= 8'h00;
      vhi_q      <= 8'h00;
      mem_rd_q   <= 1'b0;
      mem_addr_q <= 15'h0000;
    end else begin
      mem_rd_q <= vis_go || state_q == ST_FHI;
      if (vis_go) begin
        tbase_q    <= vis_block;
        tofs_q     <= win_ofs;
        mem_addr_q <= {vis_block, win_ofs};
      end else if (state_q == ST_FHI) begin
        mem_addr_q <= {tbase_q, tofs_q | 8'h01};
      end
      if (state_q == ST_FLO) begin
        vhi_q <= MEM_DATA;
      end
    end
  end

  // ===================================================
  // program counter loads
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pc_load_q  <= 1'b0;
      pc_value_q <= 15'h0000;
    end else begin
      pc_load_q <= 1'b0;
      if (state_q == ST_FWAIT) begin
        pc_load_q  <= 1'b1;
        pc_value_q <= {vhi_q[6:0], MEM_DATA};
      end else if (state_q == ST_POP) begin
        pc_load_q  <= 1'b1;
        pc_value_q <= STACK_IN;
      end else if (state_q == ST_ACK && state_d == ST_IDLE) begin
        pc_load_q  <= 1'b1;
        pc_value_q <= ENTRY_ADDR;
      end
    end
  end

  // ===================================================
  // register read port
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= 8'h00;
      if (RD) begin
        unique case (ADDR)
          REG_CTRL:   rdata_q <= {7'h00, gie_q};
          REG_STATUS: rdata_q <= {5'h00, busy_q, any_act, gie_q};
          REG_WINNER: rdata_q <= win_ofs;
          REG_PC_HI:  rdata_q <= {1'b0, pc_value_q[14:8]};
          REG_PC_LO:  rdata_q <= pc_value_q[7:0];
          default:    rdata_q <= 8'h00;
        endcase
      end
    end
  end

  assign RDATA      = rdata_q;
  assign MEM_RD     = mem_rd_q;
  assign MEM_ADDR   = mem_addr_q;
  assign STACK_PUSH = push_q;
  assign STACK_OUT  = push_data_q;
  assign STACK_POP  = pop_q;
  assign PC_LOAD    = pc_load_q;
  assign PC_VALUE   = pc_value_q;
  assign GLOBAL_INTERRUPT_ENABLE        = gie_q;
  assign BUSY       = busy_q;

  // ===================================================
  // checks
  localparam int ACK_LAT = int'(ACK_TC) * int'(TC_CLKS) + 1;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_fetch_pair;
    mem_rd_q && mem_addr_q[0] == 1'b0 ##1
    mem_rd_q && mem_addr_q[0] == 1'b1;
  endsequence

  sequence s_vec_load;
    pc_load_q && pc_value_q == {vhi_q[6:0], $past(MEM_DATA)};
  endsequence

  a_return_from_interrupt_op_sets_gie: assert property (
    return_from_interrupt_op_go |=> gie_q && pop_q ##1 pc_load_q &&
      pc_value_q == $past(STACK_IN))
    else $error("return did not restore enable and pc");

  a_ack_push_clear: assert property (
    take |=> !gie_q && push_q && push_data_q == $past(CORE.op_pc))
    else $error("acknowledge did not clear enable or push pc");

  a_ack_entry_time: assert property (
    take |-> ##ACK_LAT pc_load_q && pc_value_q == ENTRY_ADDR)
    else $error("entry jump not at the seventh instruction cycle");

  a_ack_gated_enable: assert property (
    CORE.instr_start && !gie_q |=> !push_q)
    else $error("source taken with global enable clear");

  a_vis_table_addr: assert property (
    vis_go |=> mem_addr_q[14:8] == $past(CORE.op_pc[14:8]) +
      {6'h00, $past(CORE.op_pc[7:0]) == BLOCK_LAST} &&
      mem_addr_q[7:0] == $past(win_ofs))
    else $error("table address not formed from block and winner");

  a_vis_fetch_seq: assert property (
    vis_go |=> s_fetch_pair ##2 s_vec_load)
    else $error("vector fetch or load sequence wrong");

  a_default_vec: assert property (
    vis_go && !any_act |=> mem_addr_q[7:0] == OFS_DEFAULT)
    else $error("default vector not used");

  a_trap_ranks_top: assert property (
    vis_go && TRAP_PEND |=> mem_addr_q[7:0] == OFS_TRAP)
    else $error("software trap did not win");

  a_ext_over_rest: assert property (
    vis_go && !TRAP_PEND && act[0] |=> mem_addr_q[7:0] == SLOT_OFS[0])
    else $error("external source did not outrank the rest");

endmodule
`default_nettype wire

// File: ivap_pkg.sv
// constants and carrier types for the interrupt vector arbiter
package ivap_pkg;
  // ===================================================
  // widths and source count
  localparam int NSRC = 10;
  // ===================================================
  // register offsets and fields
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h01;
  localparam logic [7:0] REG_WINNER  = 8'h02;
  localparam logic [7:0] REG_PC_HI   = 8'h03;
  localparam logic [7:0] REG_PC_LO   = 8'h04;
  localparam int         CTRL_GIE    = 0;
  localparam int         STAT_GIE    = 0;
  localparam int         STAT_ACTIVE = 1;
  localparam int         STAT_BUSY   = 2;
  localparam logic       GIE_RST     = 1'b0;
  // ===================================================
  // program memory layout
  localparam logic [14:0] ENTRY_ADDR  = 15'h00FF;
  localparam logic [7:0]  BLOCK_LAST  = 8'hFF;
  localparam logic [7:0]  OFS_TRAP    = 8'hFE;
  localparam logic [7:0]  OFS_DEFAULT = 8'hE0;
  // slot offsets, index 0 ranks highest among maskable sources
  localparam logic [NSRC-1:0][7:0] SLOT_OFS = {
    8'hE2, 8'hE4, 8'hE6, 8'hE8, 8'hEA,
    8'hF2, 8'hF4, 8'hF6, 8'hF8, 8'hFA
  };
  // ===================================================
  // timing
  localparam logic [3:0] TC_CLKS = 4'd10;
  localparam logic [3:0] ACK_TC  = 4'd7;
  // ===================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ACK   = 3'b001,
    ST_FHI   = 3'b010,
    ST_FLO   = 3'b011,
    ST_FWAIT = 3'b100,
    ST_POP   = 3'b101
  } ivap_state_t;
  typedef struct packed {
    logic        instr_start;
    logic        op_vis;
    logic        op_return_from_interrupt_op;
    logic [14:0] op_pc;
  } ivap_core_t;
endpackage

// File: ivap_core_model.sv
// program memory and return stack model facing the arbiter
`timescale 1ns/1ps
`default_nettype none
module ivap_core_model (
  input  wire logic        clk,
  input  wire logic        mem_rd,
  input  wire logic [14:0] mem_addr,
  input  wire logic        push,
  input  wire logic [14:0] push_pc,
  input  wire logic        pop,
  output logic [7:0]       mem_data,
  output logic [14:0]      pop_pc
);
  logic [7:0]  data_q = 8'h5A;
  logic [14:0] top_q = 15'h0000;
  // ======
  // byte valid one cycle after the read, scrambled otherwise
  always @(posedge clk) begin
    if (mem_rd) begin
      data_q <= mem_addr[7:0] ^ {1'b0, mem_addr[14:8]} ^ 8'h25;
    end else begin
      data_q <= ~data_q;
    end
  end
  // one deep stack, the bench never nests service
  always @(posedge clk) begin
    if (push) begin
      top_q <= push_pc;
    end
  end
  // top word stands while pop is high, since the arbiter samples it then
  assign mem_data = data_q;
  assign pop_pc   = pop ? top_q : ~top_q;
endmodule
`default_nettype wire

// File: tb.sv
// self-checking bench for the interrupt vector arbiter
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ivap_pkg::*;
  // ======
  // stimulus and observed signals
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  ivap_core_t  core = '0;
  logic [9:0]  pend = '0;
  logic [9:0]  en = '0;
  logic        trap = 1'b0;
  logic        nmi = 1'b0;
  logic [7:0]  addr = '0;
  logic [7:0]  wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata, mem_data;
  logic [14:0] mem_addr, stk_out, stk_in, pc_value, pc;
  logic        mem_rd, push, pop, pc_load, global_interrupt_enable, busy;
  logic [31:0] r;
  int          miscompares = 0;
  int          checks = 0;
  integer      seed = 32'hbbf1;
  logic [7:0]  slot [10] = '{8'hFA, 8'hF8, 8'hF6, 8'hF4, 8'hF2,
                             8'hEA, 8'hE8, 8'hE6, 8'hE4, 8'hE2};
  always #2 clk = ~clk;
  ivap_top u_dut (
    .CLK(clk), .RST_N(rst_n), .CORE(core), .PEND(pend), .ENABLE(en),
    .TRAP_PEND(trap), .NMI_BUSY(nmi), .MEM_DATA(mem_data),
    .STACK_IN(stk_in), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .MEM_RD(mem_rd), .MEM_ADDR(mem_addr),
    .STACK_PUSH(push), .STACK_OUT(stk_out), .STACK_POP(pop),
    .PC_LOAD(pc_load), .PC_VALUE(pc_value), .GLOBAL_INTERRUPT_ENABLE(global_interrupt_enable), .BUSY(busy)
  );
  ivap_core_model u_mem (
    .clk(clk), .mem_rd(mem_rd), .mem_addr(mem_addr), .push(push),
    .push_pc(stk_out), .pop(pop), .mem_data(mem_data), .pop_pc(stk_in)
  );
  // ======
  // checking and bus tasks
  task automatic chk(input string what, input logic [15:0] got,
                     input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] win();
    if (trap) return 8'hFE;
    for (int i = 0; i < 10; i++) if (pend[i] & en[i]) return slot[i];
    return 8'hE0;
  endfunction
  function automatic logic [7:0] mem(input logic [14:0] a);
    return a[7:0] ^ {1'b0, a[14:8]} ^ 8'h25;
  endfunction
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input string w, input logic [7:0] a,
                      input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(w, rdata, e);
  endtask
  // one cycle core pulse: 0 select, 1 return, 2 instruction start
  task automatic op(input int k, input logic [14:0] p);
    @(posedge clk);
    core <= {k == 2, k == 0, k == 1, p};
    @(posedge clk);
    core <= {3'b000, p};
  endtask
  task automatic take(input logic yes, input logic [14:0] p);
    int n;
    op(2, p);
    #1 chk("push", push, yes);
    if (yes) begin
      chk("pushed pc", stk_out, p);
      chk("gie cleared", global_interrupt_enable, 1'b0);
      chk("busy", busy, 1'b1);
      n = 1;
      while (pc_load !== 1'b1 && n < 100) begin
        @(posedge clk);
        #1 n++;
      end
      chk("ack cycles", n, 71);
      chk("entry", pc_value, ENTRY_ADDR);
    end
  endtask
  task automatic ret(input logic [14:0] p);
    op(1, p);
    #1 chk("gie set", global_interrupt_enable, 1'b1);
    chk("pop", pop, 1'b1);
    @(posedge clk);
    #1 chk("popped pc", {pc_load, pc_value}, {1'b1, p});
  endtask
  task automatic vector_select_op(input logic [14:0] p);
    logic [14:0] hi;
    logic [7:0]  b;
    op(0, p);
    hi = {p[14:8] + {6'd0, p[7:0] == 8'hFF}, win()};
    b = mem(hi);
    #1 chk("hi addr", {mem_rd, mem_addr}, {1'b1, hi});
    @(posedge clk);
    #1 chk("lo addr", {mem_rd, mem_addr}, {1'b1, hi | 15'd1});
    repeat (2) @(posedge clk);
    #1 chk("vis load", pc_load, 1'b1);
    chk("vector", pc_value, {b[6:0], mem(hi | 15'd1)});
  endtask
  // ======
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rreg("ctrl reset", REG_CTRL, 8'h00);
    wreg(REG_CTRL, 8'h01);
    rreg("status", REG_STATUS, 8'h01);
    wreg(8'h3C, 8'hFF);
    rreg("unmapped", 8'h3C, 8'h00);
    trap <= 1'b1;
    take(1'b0, 15'h0123);
    trap <= 1'b0;
    pend <= 10'b0010000100;
    en <= 10'h3FF;
    nmi <= 1'b1;
    take(1'b0, 15'h0123);
    nmi <= 1'b0;
    en <= 10'h000;
    take(1'b0, 15'h0123);
    en <= 10'h3FF;
    take(1'b1, 15'h0123);
    rreg("pc lo", REG_PC_LO, 8'hFF);
    vector_select_op(ENTRY_ADDR);
    pend[2] <= 1'b0;
    ret(15'h0123);
    take(1'b1, 15'h0123);
    vector_select_op(ENTRY_ADDR);
    wreg(REG_CTRL, 8'h00);
    take(1'b0, 15'h0200);
    // sources identified only through the select op, looping back
    for (int k = 0; k < 40; k++) begin
      r = $random(seed);
      pc = r[30:16];
      if (k % 3 == 0) pc[7:0] = 8'hFF;
      @(posedge clk);
      trap <= (k == 10) | (k > 11 & r[31] & r[30]);
      pend <= k < 10 ? (r[9:0] | 10'h1 << k) & (10'h3FF << k) : r[9:0];
      en <= k == 11 ? ~r[9:0] : (k < 10 ? 10'h3FF : r[19:10]);
      vector_select_op(pc);
    end
    summarize();
  end
endmodule
`default_nettype wire
